// >>> design/e3rx_line_decoder.sv
module e3rx_line_decoder
	import e3rx_pkg::*;
#(
	parameter int FRAME_BITS = FRAME_BITS_DEF,
	parameter int ONE_SEC_CYCLES = ONE_SEC_CYC
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic rxPositiveRail,
	input wire logic rxNegativeRail,
	input wire logic rxLineClock,
	output logic payloadBit,
	output logic payloadValid,
	output logic overheadBit,
	output logic overheadValid,
	output logic hdlcBit,
	output logic hdlcValid,
	output logic acquisitionMode,
	output logic codeViolationFlag,
	output logic irq
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [3:0] stat;
		logic [3:0] mask;
		logic [15:0] evtCnt;
		logic [7:0] evtShadow;
		logic [15:0] secAcc;
		logic [15:0] secReg;
		logic [24:0] secTick;
		logic [LOSS_W-1:0] lossCnt;
		logic locPrev;
		logic clkPrev;
		logic awHeld;
		logic [11:0] awAddr;
		logic wHeld;
		logic [7:0] wData;
		logic wLane;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		e3rx_fstate_t fstate;
		logic [15:0] sh;
		logic [12:0] bitCnt;
		logic [1:0] badCnt;
		logic [4:0] oofCnt;
		logic payBit;
		logic payValid;
		logic ohBit;
		logic ohValid;
		logic hdlcBit;
		logic hdlcValid;
	} e3rx_top_t;

	e3rx_top_t q;
	e3rx_top_t n;
	logic [2:0] syncd;
	logic lineRise;
	logic lineFall;
	logic symValid;
	logic dValid;
	logic dBit;
	logic lcvPulse;
	logic zeroRunPulse;
	logic awTake;
	logic wTake;
	logic arTake;
	logic wrGo;
	logic [7:0] wrIdx;
	logic [7:0] rdIdx;
	logic [3:0] stClr;
	logic reframe;
	logic rdEvtHi;
	logic rdEvtLo;
	logic faMatch;
	logic frameWrap;
	logic synced;
	logic ovhPos;
	logic hdlcPos;
	logic clock_loss_indication;
	logic tick;

	function automatic logic regHit(input logic [11:0] a);
		regHit = (a[11:10] == 2'h0) && (a[9:2] inside {IDX_CTRL, IDX_EVT_HI, IDX_EVT_LO,
			IDX_SEC_HI, IDX_SEC_LO, IDX_STAT, IDX_MASK});
	endfunction

	// ----------------------------------------
	// Line side: synchroniser, edge pick, decoder
	// ----------------------------------------
	e3rx_sync u_sync (
		.clk(clk),
		.rstn(rstn),
		.asyncIn({rxLineClock, rxNegativeRail, rxPositiveRail}),
		.syncOut(syncd)
	);

	// Rails share the clock's delay, so the edge strobe samples both aligned
	assign lineRise = syncd[2] & ~q.clkPrev;
	assign lineFall = ~syncd[2] & q.clkPrev;
	assign symValid = q.ctrl[CTRL_RX_INV] ? lineFall : lineRise;

	e3rx_hdb3 u_dec (
		.clk(clk),
		.rstn(rstn),
		.symValid(symValid),
		.symPos(syncd[0]),
		.symNeg(syncd[1]),
		.singleRail(q.ctrl[CTRL_SINGLE]),
		.amiOnly(q.ctrl[CTRL_AMI]),
		.bitValid(dValid),
		.bitData(dBit),
		.lcvPulse(lcvPulse),
		.zeroRunPulse(zeroRunPulse)
	);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign awready = ~q.awHeld & ~q.bvalid;
	assign wready = ~q.wHeld & ~q.bvalid;
	assign awTake = awvalid & awready;
	assign wTake = wvalid & wready;
	assign wrGo = q.awHeld & q.wHeld & ~q.bvalid;
	assign wrIdx = q.awAddr[9:2];
	assign arready = ~q.rvalid;
	assign arTake = arvalid & arready;
	assign rdIdx = araddr[9:2];
	assign stClr = (wrGo && q.wLane && regHit(q.awAddr) && wrIdx == IDX_STAT)
		? q.wData[3:0] : 4'h0;
	assign reframe = wrGo && q.wLane && regHit(q.awAddr) && wrIdx == IDX_CTRL
		&& q.wData[CTRL_REFRAME];
	// Reading the high byte freezes the low byte so the pair reads coherent
	assign rdEvtHi = arTake && regHit(araddr) && rdIdx == IDX_EVT_HI;
	assign rdEvtLo = arTake && regHit(araddr) && rdIdx == IDX_EVT_LO;

	// ----------------------------------------
	// Framer helpers and timers
	// ----------------------------------------
	assign faMatch = ({q.sh[14:0], dBit} == FA_WORD);
	assign frameWrap = (q.bitCnt == 13'(FRAME_BITS - 1));
	assign synced = (q.fstate == FR_INFRAME) || (q.fstate == FR_OOF);
	assign ovhPos = synced && ((q.bitCnt < 13'(HEAD_BITS))
		|| (q.bitCnt >= 13'(FRAME_BITS - FA_BITS)));
	assign hdlcPos = synced && (q.bitCnt >= 13'(HDLC_FIRST)) && (q.bitCnt <= 13'(HDLC_LAST));
	assign clock_loss_indication = (q.lossCnt == LOSS_W'(LOSS_CYC)) && ~q.ctrl[CTRL_RXLOC_OFF];
	assign tick = (q.secTick == 25'(ONE_SEC_CYCLES - 1));

	// Next state of the whole block
	always_comb
	begin
		n = q;
		n.clkPrev = syncd[2];
		n.locPrev = clock_loss_indication;
		// Line clock watchdog
		if (lineRise | lineFall)
			n.lossCnt = '0;
		else if (q.lossCnt != LOSS_W'(LOSS_CYC))
			n.lossCnt = q.lossCnt + LOSS_W'(1);

		// Write address and data may arrive in either order
		if (awTake)
		begin
			n.awHeld = 1'b1;
			n.awAddr = awaddr;
		end
		if (wTake)
		begin
			n.wHeld = 1'b1;
			n.wData = wdata[7:0];
			n.wLane = wstrb[0];
		end
		if (bvalid & bready)
			n.bvalid = 1'b0;
		if (wrGo)
		begin
			n.awHeld = 1'b0;
			n.wHeld = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = regHit(q.awAddr) ? RESP_OKAY : RESP_SLVERR;
			if (q.wLane && regHit(q.awAddr))
			begin
				if (wrIdx == IDX_CTRL)
					n.ctrl = {q.wData[7], 1'b0, q.wData[5:0]};
				if (wrIdx == IDX_MASK)
					n.mask = q.wData[3:0];
			end
		end

		// Read answers one cycle after the address is taken
		if (rvalid & rready)
			n.rvalid = 1'b0;
		if (arTake)
		begin
			n.rvalid = 1'b1;
			n.rresp = regHit(araddr) ? RESP_OKAY : RESP_SLVERR;
			n.rdata = 32'h0;
			if (regHit(araddr))
			begin
				case (rdIdx)
					IDX_CTRL: n.rdata[7:0] = {q.ctrl[7], clock_loss_indication, q.ctrl[5:0]};
					IDX_EVT_HI: n.rdata[7:0] = q.evtCnt[15:8];
					IDX_EVT_LO: n.rdata[7:0] = q.evtShadow;
					IDX_SEC_HI: n.rdata[7:0] = q.secReg[15:8];
					IDX_SEC_LO: n.rdata[7:0] = q.secReg[7:0];
					IDX_STAT: n.rdata[3:0] = q.stat;
					IDX_MASK: n.rdata[3:0] = q.mask;
					default: n.rdata = 32'h0;
				endcase
			end
		end
		if (rdEvtHi)
			n.evtShadow = q.evtCnt[7:0];

		// Event counter saturates; a hit in the clearing cycle is kept
		if (rdEvtLo)
			n.evtCnt = {15'h0, lcvPulse};
		else if (lcvPulse && q.evtCnt != 16'hffff)
			n.evtCnt = q.evtCnt + 16'h1;

		// One-second window: accumulate, then publish at the tick
		if ((lcvPulse | zeroRunPulse) && q.secAcc != 16'hffff)
			n.secAcc = q.secAcc + 16'h1;
		if (tick)
		begin
			n.secReg = n.secAcc;
			n.secAcc = 16'h0;
			n.secTick = 25'h0;
		end
		else
			n.secTick = q.secTick + 25'h1;

		// Framer moves on decoded bits, so it follows the line clock; leaving LOF and a reframe act at once
		n.payValid = 1'b0;
		n.ohValid = 1'b0;
		n.hdlcValid = 1'b0;
		if (dValid)
		begin
			n.sh = {q.sh[14:0], dBit};
			n.bitCnt = frameWrap ? 13'h0 : q.bitCnt + 13'h1;
			unique case (q.fstate)
				FR_SEARCH:
				begin
					if (faMatch)
					begin
						n.fstate = FR_VERIFY;
						n.bitCnt = 13'h0;
					end
				end
				FR_VERIFY:
				begin
					if (frameWrap)
						n.fstate = faMatch ? FR_INFRAME : FR_SEARCH;
				end
				FR_INFRAME:
				begin
					if (frameWrap && faMatch)
						n.badCnt = 2'h0;
					else if (frameWrap && q.badCnt == 2'(OOF_BAD_FRAMES - 1))
					begin
						n.fstate = FR_OOF;
						n.badCnt = 2'h0;
						n.oofCnt = 5'h0;
					end
					else if (frameWrap)
						n.badCnt = q.badCnt + 2'h1;
				end
				FR_OOF:
				begin
					if (frameWrap && faMatch)
						n.fstate = FR_INFRAME;
					else if (frameWrap && q.oofCnt == 5'(OOF_MAX_FRAMES - 1))
						n.fstate = FR_LOF;
					else if (frameWrap)
						n.oofCnt = q.oofCnt + 5'h1;
				end
				FR_LOF:
				begin
					n.fstate = FR_SEARCH;
				end
			endcase
			// Out-of-frame keeps routing on the last good alignment
			n.payBit = dBit;
			n.payValid = ~ovhPos;
			n.ohBit = dBit;
			n.ohValid = ovhPos;
			n.hdlcBit = dBit;
			n.hdlcValid = hdlcPos;
		end
		// Loss of frame drops the alignment straight away
		if (q.fstate == FR_LOF || reframe)
			n.fstate = FR_SEARCH;

		// Sticky status; a new event beats a clear in the same cycle
		n.stat = q.stat & ~stClr;
		if (lcvPulse)
			n.stat[ST_LCV] = 1'b1;
		if (n.fstate == FR_OOF && q.fstate != FR_OOF)
			n.stat[ST_OOF] = 1'b1;
		if (n.fstate == FR_LOF && q.fstate != FR_LOF)
			n.stat[ST_LOF] = 1'b1;
		if (clock_loss_indication & ~q.locPrev)
			n.stat[ST_LOC] = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			q <= '0;
			q.ctrl <= CTRL_RESET;
			q.fstate <= FR_SEARCH;
		end
		else
			q <= n;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign payloadBit = q.payBit;
	assign payloadValid = q.payValid;
	assign overheadBit = q.ohBit;
	assign overheadValid = q.ohValid;
	assign hdlcBit = q.hdlcBit;
	assign hdlcValid = q.hdlcValid;
	assign acquisitionMode = (q.fstate != FR_INFRAME);
	assign codeViolationFlag = lcvPulse;
	assign irq = |(q.stat & q.mask);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence s_lcv_counted;
		lcvPulse && !rdEvtLo && q.evtCnt != 16'hffff;
	endsequence
	sequence s_rise_seen;
		!syncd[2] ##1 syncd[2];
	endsequence

	a_evt_count_inc : assert property (
		s_lcv_counted |=> q.evtCnt == $past(q.evtCnt) + 16'h1)
		else $error("event counter missed a violation");
	a_sec_accum : assert property (
		(lcvPulse || zeroRunPulse) && !tick && q.secAcc != 16'hffff
		|=> q.secAcc == $past(q.secAcc) + 16'h1)
		else $error("one-second accumulator missed an event");
	a_edge_select : assert property (
		s_rise_seen ##0 (!q.ctrl[CTRL_RX_INV] && q.clkPrev == $past(syncd[2])) |-> symValid)
		else $error("rising edge not sampled");
	a_verify_fail : assert property (
		q.fstate == FR_VERIFY && dValid && frameWrap && !faMatch |=> q.fstate == FR_SEARCH)
		else $error("failed verification not back to search");
	a_lof_exit : assert property (
		q.fstate == FR_LOF |=> q.fstate == FR_SEARCH && acquisitionMode)
		else $error("loss of frame did not restart search");
	a_stream_route : assert property (
		dValid && q.fstate == FR_SEARCH
		|=> payloadValid && !overheadValid && payloadBit == $past(dBit))
		else $error("decoded bit not delivered");
endmodule // e3rx_line_decoder

// >>> design/e3rx_pkg.sv
package e3rx_pkg;
	// ----------------------------------------
	// Register indices, byte address = 4 * index
	// ----------------------------------------
	localparam logic [7:0] IDX_CTRL = 8'h01;
	localparam logic [7:0] IDX_EVT_HI = 8'h50;
	localparam logic [7:0] IDX_EVT_LO = 8'h51;
	localparam logic [7:0] IDX_SEC_HI = 8'h6e;
	localparam logic [7:0] IDX_SEC_LO = 8'h6f;
	localparam logic [7:0] IDX_STAT = 8'h70;
	localparam logic [7:0] IDX_MASK = 8'h71;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'ha0;
	localparam int CTRL_REFRAME = 0;
	localparam int CTRL_RX_INV = 1;
	localparam int CTRL_SINGLE = 3;
	localparam int CTRL_AMI = 4;
	localparam int CTRL_RXLOC_OFF = 5;
	localparam int CTRL_LOC = 6;
	localparam int ST_LCV = 0;
	localparam int ST_OOF = 1;
	localparam int ST_LOF = 2;
	localparam int ST_LOC = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Timing at a 25 MHz clock
	// ----------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int ONE_SEC_MS = 1000;
	localparam int ONE_SEC_CYC = ONE_SEC_MS * 1000 * CLK_MHZ;
	localparam int LOSS_NS = 2000;
	localparam int LOSS_CYC = (LOSS_NS * CLK_MHZ + 999) / 1000;
	localparam int LOSS_W = 6;

	// ----------------------------------------
	// Framing
	// ----------------------------------------
	localparam logic [15:0] FA_WORD = 16'hf628;
	localparam int FRAME_BYTES = 537;
	localparam int FRAME_BITS_DEF = FRAME_BYTES * 8;
	localparam int FA_BITS = 16;
	localparam int HEAD_BITS = 40;
	localparam int HDLC_FIRST = 32;
	localparam int HDLC_LAST = 39;
	localparam int OOF_BAD_FRAMES = 4;
	localparam int OOF_MAX_FRAMES = 24;

	typedef enum logic [4:0] {
		FR_SEARCH = 5'h01,
		FR_VERIFY = 5'h02,
		FR_INFRAME = 5'h04,
		FR_OOF = 5'h08,
		FR_LOF = 5'h10
	} e3rx_fstate_t;
endpackage

// >>> design/e3rx_sync.sv
module e3rx_sync
	import e3rx_pkg::*;
#(
	parameter int W = 3
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} e3rx_sync_t;

	e3rx_sync_t q;
	e3rx_sync_t n;

	// Two stages; only the second stage is seen outside
	always_comb
	begin
		n.first = asyncIn;
		n.second = q.first;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			q <= '0;
		else
			q <= n;
	end

	assign syncOut = q.second;
endmodule // e3rx_sync

// >>> design/e3rx_hdb3.sv
module e3rx_hdb3
	import e3rx_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic symValid,
	input wire logic symPos,
	input wire logic symNeg,
	input wire logic singleRail,
	input wire logic amiOnly,
	output logic bitValid,
	output logic bitData,
	output logic lcvPulse,
	output logic zeroRunPulse
);
	typedef struct packed {
		logic lastNeg;
		logic [1:0] mark;
		logic [2:0] pipe;
		logic [1:0] zeros;
		logic outValid;
		logic outBit;
		logic code_violation_flag;
		logic zr;
	} e3rx_dec_t;

	e3rx_dec_t q;
	e3rx_dec_t n;
	logic pulse;
	logic both;
	logic viol;
	logic goodV;

	// A same-polarity pulse after two empty slots is a legal substitution
	assign pulse = symPos | symNeg;
	assign both = symPos & symNeg;
	assign viol = pulse & ~both & (symNeg == q.lastNeg);
	assign goodV = viol & ~amiOnly & ~q.mark[0] & ~q.mark[1];

	// Three-symbol delay lets a late violation wipe the B slot
	always_comb
	begin
		n = q;
		n.outValid = symValid;
		n.code_violation_flag = 1'b0;
		n.zr = 1'b0;
		if (symValid)
		begin
			if (singleRail)
			begin
				n.outBit = q.pipe[2];
				n.pipe = {q.pipe[1:0], symPos};
			end
			else
			begin
				n.outBit = goodV ? 1'b0 : q.pipe[2];
				n.pipe = goodV ? 3'h0 : {q.pipe[1:0], pulse};
				n.code_violation_flag = both | (viol & ~goodV);
				if (pulse & ~both)
					n.lastNeg = symNeg;
				n.mark = {q.mark[0], pulse};
				n.zeros = pulse ? 2'h0 : ((q.zeros == 2'h3) ? q.zeros : q.zeros + 2'h1);
				n.zr = ~pulse & ~amiOnly & (q.zeros == 2'h2);
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			q <= '0;
			q.lastNeg <= 1'b1;
		end
		else
			q <= n;
	end

	assign bitValid = q.outValid;
	assign bitData = q.outBit;
	assign lcvPulse = q.code_violation_flag;
	assign zeroRunPulse = q.zr;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence s_dual_sym;
		symValid && !singleRail;
	endsequence

	a_rails_both_lcv : assert property (
		s_dual_sym ##0 (symPos && symNeg) |=> lcvPulse && bitValid)
		else $error("both rails high not flagged");
	a_sub_zeroes : assert property (
		s_dual_sym ##0 goodV |=> bitValid && !bitData && q.pipe == 3'h0)
		else $error("substitution not replaced by zeros");
	a_zero_run : assert property (
		s_dual_sym ##0 (!pulse && !amiOnly && q.zeros == 2'h2) |=> zeroRunPulse)
		else $error("third zero not reported");
	a_single_clean : assert property (
		symValid && singleRail |=> !lcvPulse && bitData == $past(q.pipe[2]))
		else $error("single rail data altered");
endmodule // e3rx_hdb3

// >>> dv/e3rx_liu_model.sv
module e3rx_liu_model (
	input wire logic fallEdge,
	output logic lineClk,
	output logic posRail,
	output logic negRail
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Far-end line unit, 320 ns per symbol
	// ----------------------------------------
	logic lastPos = 1'b0;
	int sinceV = 0;

	// Clock idles low between bursts
	initial
	begin
		lineClk = 1'b0;
		posRail = 1'b0;
		negRail = 1'b0;
	end

	// One symbol; rails show the inverse away from the sampling edge so a wrong edge is seen
	task automatic put(input logic p, input logic n);
		if (!fallEdge)
		begin
			{posRail, negRail} = {p, n};
			#80 lineClk = 1'b1;
			#80 {posRail, negRail} = {~p, ~n};
			#80 lineClk = 1'b0;
			#80;
		end
		else
		begin
			#80 lineClk = 1'b1;
			#80 {posRail, negRail} = {p, n};
			#80 lineClk = 1'b0;
			#80 {posRail, negRail} = {~p, ~n};
		end
	endtask

	// Mark with a polarity chosen by the caller
	task automatic mark(input logic pol);
		put(pol, ~pol);
		lastPos = pol;
	endtask

	// Encoder with four-symbol lookahead inside one word
	task automatic send_word(input logic [63:0] w, input int n, input bit hdb3);
		int i;
		i = n - 1;
		while (i >= 0)
		begin
			if (hdb3 && i >= 3 && w[i -: 4] == 4'h0)
			begin
				if (sinceV[0])
					put(1'b0, 1'b0);
				else
					mark(~lastPos);
				put(1'b0, 1'b0);
				put(1'b0, 1'b0);
				put(lastPos, ~lastPos);
				sinceV = 0;
				i -= 4;
			end
			else if (w[i])
			begin
				mark(~lastPos);
				sinceV++;
				i--;
			end
			else
			begin
				put(1'b0, 1'b0);
				i--;
			end
		end
	endtask

	// Symbol forced by the bench, for illegal sequences and single-rail data
	task automatic send_raw(input logic p, input logic n);
		put(p, n);
		if (p != n)
			lastPos = p;
	endtask
endmodule // e3rx_liu_model

// >>> dv/e3rx_line_decoder_tb.sv
module e3rx_line_decoder_tb
	import e3rx_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SEC = 3000;
	logic clk = 1'b0, rstn = 1'b0, fallEdge = 1'b0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rndState = 32'hff23;
	logic [3:0] wstrb = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rxLineClock, rxPositiveRail, rxNegativeRail;
	logic payloadBit, payloadValid, overheadBit, overheadValid, hdlcBit, hdlcValid;
	logic acquisitionMode, codeViolationFlag, irq;
	logic [1:0] bresp, rresp;
	logic obs[$], expq[$];
	int num_errors = 0, total_checks = 0, violCnt = 0, hdlcCnt = 0;
	bit single = 0, hdb3 = 1;

	// Short frame and short second keep the run brief
	e3rx_line_decoder #(.FRAME_BITS(64), .ONE_SEC_CYCLES(SEC)) e3rx_line_decoder_i (.clk, .rstn,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rxPositiveRail,
		.rxNegativeRail, .rxLineClock, .payloadBit, .payloadValid, .overheadBit, .overheadValid,
		.hdlcBit, .hdlcValid, .acquisitionMode, .codeViolationFlag, .irq);
	e3rx_liu_model e3rx_liu_model_i (.fallEdge, .lineClk(rxLineClock), .posRail(rxPositiveRail),
		.negRail(rxNegativeRail));

	// 25 MHz clock
	initial
		forever #20 clk = ~clk;

	// Collect the decoded stream and event pulses
	always @(posedge clk)
	begin
		if (payloadValid === 1'b1)
			obs.push_back(payloadBit);
		else if (overheadValid === 1'b1)
			obs.push_back(overheadBit);
		if (hdlcValid === 1'b1)
			hdlcCnt++;
		if (codeViolationFlag === 1'b1)
			violCnt++;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		rndState = rndState ^ (rndState << 13);
		rndState = rndState ^ (rndState >> 17);
		rndState = rndState ^ (rndState << 5);
		return rndState;
	endfunction

	task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic check_bit(input string what, input logic e, input logic g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Both write channels offered together, each dropped once taken
	task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		int t;
		@(posedge clk);
		awaddr <= {2'h0, idx, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (t = 0; t < 50 && bvalid !== 1'b1; t++)
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		check_val("write response", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic axi_read(input logic [7:0] idx, input logic [1:0] er, output logic [31:0] d);
		int t;
		@(posedge clk);
		araddr <= {2'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (t = 0; t < 50 && rvalid !== 1'b1; t++)
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		d = rdata;
		check_val("read response", {30'h0, er}, {30'h0, rresp});
	endtask

	// Single rail puts random noise on the unused rail
	task automatic send(input logic [63:0] w, input int n);
		int i;
		for (i = n - 1; i >= 0; i--)
			expq.push_back(w[i]);
		if (!single)
			e3rx_liu_model_i.send_word(w, n, hdb3);
		else
			for (i = n - 1; i >= 0; i--)
				e3rx_liu_model_i.send_raw(w[i], 1'(rnd() >> 9));
	endtask

	// Three symbols stay inside the decoder until more arrive
	task automatic resync;
		send(64'hf, 4);
		repeat (30) @(posedge clk);
		obs.delete();
		expq = '{1'b1, 1'b1, 1'b1};
	endtask

	task automatic check_stream;
		int i;
		repeat (30) @(posedge clk);
		for (i = 0; i < obs.size(); i++)
			check_bit("stream bit", expq[i], obs[i]);
		expq = expq[obs.size():$];
		obs.delete();
		check_val("bits pending", 32'd3, 32'(expq.size()));
	endtask

	// The register shows the last whole second, so two reads a second apart cover a burst
	task automatic sec_total(output logic [31:0] s);
		logic [31:0] h, l;
		repeat (5) @(posedge clk);
		axi_read(IDX_SEC_HI, RESP_OKAY, h);
		axi_read(IDX_SEC_LO, RESP_OKAY, l);
		s = {16'h0, h[7:0], l[7:0]};
		repeat (SEC) @(posedge clk);
		axi_read(IDX_SEC_HI, RESP_OKAY, h);
		axi_read(IDX_SEC_LO, RESP_OKAY, l);
		s = s + {16'h0, h[7:0], l[7:0]};
	endtask

	// Hang guard, about four times the expected run
	initial
	begin
		repeat (100000) @(posedge clk);
		num_errors++;
		$display("ERROR watchdog expected end seen hang");
		finish_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] d, s;
		logic [63:0] w;
		logic [7:0] cfg [4];
		int k, c, nv;
		cfg = '{8'ha0, 8'ha2, 8'hb0, 8'ha8};
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		axi_read(IDX_CTRL, RESP_OKAY, d);
		check_val("ctrl reset", {24'h0, CTRL_RESET}, d);
		axi_read(8'h02, RESP_SLVERR, d);
		check_val("unmapped read", 32'h0, d);
		axi_write(8'h02, 8'hff, RESP_SLVERR);
		$display("test registers done");
		for (c = 0; c < 4; c++)
		begin
			axi_write(IDX_CTRL, cfg[c], RESP_OKAY);
			fallEdge <= cfg[c][CTRL_RX_INV];
			single = cfg[c][CTRL_SINGLE];
			hdb3 = !cfg[c][CTRL_AMI];
			resync();
			violCnt = 0;
			for (k = 0; k < 8; k++)
			begin
				w = {32'h0, rnd()};
				if (k[0])
					w[12:4] = '0;
				w[0] = 1'b1;
				send(w, 32);
			end
			check_stream();
			if (!hdb3)
				e3rx_liu_model_i.send_word(64'h0f, 8, 1);
			repeat (30) @(posedge clk);
			check_val("violations", 32'(!hdb3), 32'(violCnt));
			axi_read(IDX_CTRL, RESP_OKAY, d);
			check_val("ctrl readback", {24'h0, cfg[c]}, d);
			$display("test line mode %h done", cfg[c]);
		end
		axi_write(IDX_CTRL, 8'ha0, RESP_OKAY);
		fallEdge <= 1'b0;
		single = 0;
		hdb3 = 1;
		resync();
		axi_read(IDX_EVT_HI, RESP_OKAY, d);
		axi_read(IDX_EVT_LO, RESP_OKAY, d);
		axi_write(IDX_STAT, 8'hff, RESP_OKAY);
		// Two windows flush any violation left by the rail mode switch
		repeat (2 * SEC) @(posedge clk);
		nv = 2 + int'(rnd() % 5);
		violCnt = 0;
		for (k = 0; k < nv; k++)
		begin
			e3rx_liu_model_i.send_word(64'h1, 1, 1);
			e3rx_liu_model_i.send_raw(e3rx_liu_model_i.lastPos, !e3rx_liu_model_i.lastPos);
		end
		e3rx_liu_model_i.send_raw(1'b1, 1'b1);
		e3rx_liu_model_i.send_word(64'h1, 4, 1);
		for (k = 0; k < nv; k++)
			e3rx_liu_model_i.send_word(64'h8, 4, 1);
		e3rx_liu_model_i.send_word(64'hf, 4, 1);
		sec_total(s);
		check_val("second total", 32'(2 * nv + 2), s);
		check_val("violation flags", 32'(nv + 1), 32'(violCnt));
		axi_read(IDX_EVT_HI, RESP_OKAY, d);
		axi_read(IDX_EVT_LO, RESP_OKAY, s);
		check_val("event count", 32'(nv + 1), {16'h0, d[7:0], s[7:0]});
		check_bit("irq masked", 1'b0, irq);
		axi_write(IDX_MASK, 8'h01, RESP_OKAY);
		check_bit("irq raised", 1'b1, irq);
		axi_write(IDX_STAT, 8'h01, RESP_OKAY);
		check_bit("irq cleared", 1'b0, irq);
		axi_write(IDX_MASK, 8'h00, RESP_OKAY);
		$display("test violations done");
		resync();
		hdlcCnt = 0;
		for (k = 0; k < 4; k++)
			send({FA_WORD, rnd(), 16'(rnd()) | 16'h1}, 64);
		check_stream();
		check_bit("maintenance mode", 1'b0, acquisitionMode);
		check_bit("hdlc delivered", 1'b1, hdlcCnt > 0);
		for (k = 0; k < 5; k++)
			send({16'h0, rnd(), 16'(rnd()) | 16'h1}, 64);
		check_stream();
		check_bit("acquisition mode", 1'b1, acquisitionMode);
		axi_read(IDX_STAT, RESP_OKAY, d);
		check_bit("oof status", 1'b1, d[ST_OOF]);
		$display("test framer done");
		finish_test();
	end
endmodule // e3rx_line_decoder_tb
